//--- common/ubs_defs.vh
`ifndef UBS_DEFS_VH
`define UBS_DEFS_VH

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define UBS_BIT_HW_RESET 7
`define UBS_BIT_BUS_RESET 6
`define UBS_BIT_BUS_ACTIVE 5
`define UBS_BIT_RESUME 4
`define UBS_BIT_EP12_IN 3
`define UBS_BIT_EP0_IN 2
`define UBS_BIT_OUT_DONE 1
`define UBS_BIT_WAKE 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define UBS_RST_HW_RESET 1'b1
`define UBS_RST_BUS_RESET 1'b0
`define UBS_RST_WAKE 1'b1
`define UBS_RST_FLAGS 5'h00
`define UBS_STATUS_WIDTH 8

`endif

//--- design/ubs_sync.v
`timescale 1ns/1ps
// ----------------------------------------
// two-stage synchroniser, one per bit
// ----------------------------------------
module ubs_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_r <= INIT;
            sync_r <= INIT;
        end
        else
        begin
            meta_r <= d_i;
            sync_r <= meta_r;
        end
    end

    assign q_o = sync_r;
endmodule

//--- design/ubs_status.v
`timescale 1ns/1ps
`include "ubs_defs.vh"

module ubs_status (
    input wire CORE_CLK_I,
    input wire RST_B_I,
    input wire SERIAL_DATA_IN_I,
    input wire SERIAL_SELECT_I,
    input wire SERIAL_CLK_I,
    input wire WAKE_I,
    input wire USB_RESET_I,
    input wire USB_ACTIVE_I,
    input wire USB_RESUME_I,
    input wire EP12_IN_ACK_I,
    input wire EP0_IN_ACK_I,
    input wire OUT_ACK_I,
    input wire STOP_OSC_I,
    input wire STOP_MCU_CLOCK_I,
    input wire [7:0] NEXT_BYTE_I,
    output wire NEXT_BYTE_REQ_O,
    output wire SERIAL_DATA_OUT_O,
    output wire [7:0] BRIDGE_STATUS_O,
    output wire STATUS_READ_O,
    output wire EP0_EN_SET_O,
    output wire STOP_OSC_O,
    output wire STOP_MCU_CLOCK_O
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    wire [4:0] pin_s;
    wire din_s;
    wire sel_s;
    wire sck_s;
    wire wake_s;
    wire usbrst_s;

    // select and clock idle high; wake idles low so bit 0 resets to 1
    ubs_sync #(.WIDTH(5), .INIT(5'h06)) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .d_i({USB_RESET_I, WAKE_I, SERIAL_CLK_I, SERIAL_SELECT_I, SERIAL_DATA_IN_I}),
        .q_o(pin_s)
    );
    assign din_s = pin_s[0];
    assign sel_s = pin_s[1];
    assign sck_s = pin_s[2];
    assign wake_s = pin_s[3];
    assign usbrst_s = pin_s[4];

    // ----------------------------------------
    // helper decoding
    // ----------------------------------------
    // one-cycle pulse when a registered level drops
    function fell_f;
        input prev_v;
        input cur_v;
        begin
            fell_f = prev_v & ~cur_v;
        end
    endfunction

    // bus activity or resume keeps both clocks running
    function run_hold_f;
        input [7:0] st_v;
        begin
            run_hold_f = st_v[`UBS_BIT_BUS_ACTIVE] | st_v[`UBS_BIT_RESUME];
        end
    endfunction

    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    reg din_d_r;
    reg sel_d_r;
    reg sck_d_r;
    wire din_fall;
    wire sel_fall;
    wire sel_rise;
    wire sck_fall;

    // delay regs reset to each pin's idle level, so no false edge after reset
    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            din_d_r <= 1'b0;
            sel_d_r <= 1'b1;
            sck_d_r <= 1'b1;
        end
        else
        begin
            din_d_r <= din_s;
            sel_d_r <= sel_s;
            sck_d_r <= sck_s;
        end
    end

    assign din_fall = fell_f(din_d_r, din_s);
    assign sel_fall = fell_f(sel_d_r, sel_s);
    assign sel_rise = fell_f(sel_s, sel_d_r);
    assign sck_fall = fell_f(sck_d_r, sck_s);

    // ----------------------------------------
    // outbound transfer sequencing
    // ----------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_ARMED = 2'h1;
    localparam ST_SHIFT = 2'h2;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [7:0] shift_r;
    reg [2:0] bit_cnt_r;
    reg [7:0] status_r;
    reg dout_r;
    // read only by the idle serial output
    reg int_latch_r;
    reg load_status;
    reg shift_en;
    reg read_done;

    always @*
    begin
        state_nxt = state_r;
        load_status = 1'b0;
        shift_en = 1'b0;
        read_done = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                if (!sel_s && din_fall)
                begin
                    load_status = 1'b1;
                    state_nxt = ST_ARMED;
                end
            end
            ST_ARMED:
            begin
                if (sel_s)
                    state_nxt = ST_IDLE;
                else if (sck_fall)
                begin
                    shift_en = 1'b1;
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT:
            begin
                if (sel_s)
                    state_nxt = ST_IDLE;
                else if (sck_fall)
                    shift_en = 1'b1;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
        // status counts as read once its last bit is presented
        if (shift_en && state_r == ST_SHIFT && bit_cnt_r == 3'h7)
            read_done = 1'b1;
    end

    reg first_byte_r;

    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            dout_r <= 1'b1;
            first_byte_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (load_status)
            begin
                shift_r <= status_r;
                bit_cnt_r <= 3'h0;
                first_byte_r <= 1'b1;
            end
            else if (shift_en)
            begin
                dout_r <= shift_r[0];
                if (bit_cnt_r == 3'h7)
                begin
                    shift_r <= NEXT_BYTE_I;
                    first_byte_r <= 1'b0;
                end
                else
                    shift_r <= {1'b0, shift_r[7:1]};
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end
            else if (state_r == ST_IDLE && sel_s)
                // select high: output carries the low-active interrupt
                dout_r <= ~int_latch_r;
        end
    end

    wire status_read;
    assign status_read = read_done & first_byte_r;
    assign NEXT_BYTE_REQ_O = shift_en & (bit_cnt_r == 3'h7);

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    reg usbrst_d_r;
    reg bus_rst_d_r;
    wire bus_reset_fall;
    wire usb_rst_rise;

    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            usbrst_d_r <= 1'b0;
            bus_rst_d_r <= 1'b0;
        end
        else
        begin
            usbrst_d_r <= usbrst_s;
            bus_rst_d_r <= status_r[`UBS_BIT_BUS_RESET];
        end
    end
    assign usb_rst_rise = fell_f(usbrst_s, usbrst_d_r);
    assign bus_reset_fall = fell_f(bus_rst_d_r, status_r[`UBS_BIT_BUS_RESET]);

    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            status_r[`UBS_BIT_HW_RESET] <= `UBS_RST_HW_RESET;
            status_r[`UBS_BIT_BUS_RESET] <= `UBS_RST_BUS_RESET;
            status_r[5:1] <= `UBS_RST_FLAGS;
            status_r[`UBS_BIT_WAKE] <= `UBS_RST_WAKE;
        end
        else
        begin
            // clear on read or bus reset
            if (status_read || usb_rst_rise)
                status_r[`UBS_BIT_HW_RESET] <= 1'b0;
            if (usbrst_s)
                status_r[`UBS_BIT_BUS_RESET] <= 1'b1;
            else if (status_read)
                status_r[`UBS_BIT_BUS_RESET] <= 1'b0;
            if (USB_ACTIVE_I)
                status_r[`UBS_BIT_BUS_ACTIVE] <= 1'b1;
            else if (status_read)
                status_r[`UBS_BIT_BUS_ACTIVE] <= 1'b0;
            status_r[`UBS_BIT_RESUME] <= USB_RESUME_I;
            if (EP12_IN_ACK_I)
                status_r[`UBS_BIT_EP12_IN] <= 1'b1;
            else if (sel_fall)
                status_r[`UBS_BIT_EP12_IN] <= 1'b0;
            if (EP0_IN_ACK_I)
                status_r[`UBS_BIT_EP0_IN] <= 1'b1;
            else if (sel_fall)
                status_r[`UBS_BIT_EP0_IN] <= 1'b0;
            if (OUT_ACK_I)
                status_r[`UBS_BIT_OUT_DONE] <= 1'b1;
            else if (sel_rise)
                status_r[`UBS_BIT_OUT_DONE] <= 1'b0;
            status_r[`UBS_BIT_WAKE] <= ~wake_s;
        end
    end

    // ----------------------------------------
    // interrupt latch
    // ----------------------------------------
    wire int_event;
    wire stopped;

    assign stopped = STOP_OSC_I | STOP_MCU_CLOCK_I;
    // wake only counts in the stop state
    assign int_event = EP12_IN_ACK_I | EP0_IN_ACK_I | OUT_ACK_I | usb_rst_rise
                     | (USB_RESUME_I & ~status_r[`UBS_BIT_RESUME]) | (wake_s & stopped);

    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            int_latch_r <= 1'b0;
        else if (int_event)
            int_latch_r <= 1'b1;
        else if (status_read)
            int_latch_r <= 1'b0;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    reg ep0_en_r;
    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            ep0_en_r <= 1'b0;
        else
            ep0_en_r <= bus_reset_fall;
    end

    assign STOP_OSC_O = STOP_OSC_I & ~run_hold_f(status_r);
    assign STOP_MCU_CLOCK_O = STOP_MCU_CLOCK_I & ~run_hold_f(status_r);
    assign EP0_EN_SET_O = ep0_en_r;
    assign SERIAL_DATA_OUT_O = dout_r;
    assign BRIDGE_STATUS_O = status_r;
    assign STATUS_READ_O = status_read;
endmodule

//--- testbench/ubs_status_chk.sv
`timescale 1ns/1ps
module ubs_status_chk (
    input wire CORE_CLK_I,
    input wire RST_B_I,
    input wire SERIAL_SELECT_I,
    input wire WAKE_I,
    input wire USB_RESET_I,
    input wire USB_ACTIVE_I,
    input wire USB_RESUME_I,
    input wire EP12_IN_ACK_I,
    input wire EP0_IN_ACK_I,
    input wire OUT_ACK_I,
    input wire [7:0] BRIDGE_STATUS_O,
    input wire STATUS_READ_O,
    input wire EP0_EN_SET_O,
    input wire STOP_OSC_O,
    input wire STOP_MCU_CLOCK_O
);
// ----------------
// status checks
// ----------------
default clocking @(posedge CORE_CLK_I); endclocking
default disable iff (!RST_B_I);
property p_wake; $stable(WAKE_I)[*6] |-> BRIDGE_STATUS_O[0] != WAKE_I; endproperty
a_wake: assert property (p_wake) else $error("wake bit wrong");
property p_busrst; USB_RESET_I[*6] |-> BRIDGE_STATUS_O[6] && !BRIDGE_STATUS_O[7]; endproperty
a_busrst: assert property (p_busrst) else $error("bus reset bits wrong");
property p_resume; $stable(USB_RESUME_I)[*6] |-> BRIDGE_STATUS_O[4] == USB_RESUME_I; endproperty
a_resume: assert property (p_resume) else $error("resume bit wrong");
property p_active; USB_ACTIVE_I[*4] |-> BRIDGE_STATUS_O[5]; endproperty
a_active: assert property (p_active) else $error("active bit not set");
property p_stop; BRIDGE_STATUS_O[5] || BRIDGE_STATUS_O[4] |-> !STOP_OSC_O && !STOP_MCU_CLOCK_O; endproperty
a_stop: assert property (p_stop) else $error("stop bits not gated");
property p_read; (!USB_RESET_I)[*4] ##0 STATUS_READ_O && !USB_ACTIVE_I |=> BRIDGE_STATUS_O[7:5] == 3'h0; endproperty
a_read: assert property (p_read) else $error("read did not clear");
property p_ep0en; $fell(BRIDGE_STATUS_O[6]) |=> EP0_EN_SET_O; endproperty
a_ep0en: assert property (p_ep0en) else $error("no ep0 enable pulse");
property p_outack; OUT_ACK_I |-> ##[1:3] BRIDGE_STATUS_O[1]; endproperty
a_outack: assert property (p_outack) else $error("out done not set");
property p_selrise; $rose(SERIAL_SELECT_I) ##1 (!OUT_ACK_I)[*5] |-> !BRIDGE_STATUS_O[1]; endproperty
a_selrise: assert property (p_selrise) else $error("out done not cleared");
property p_selfall; $fell(SERIAL_SELECT_I) ##1 (!(EP12_IN_ACK_I || EP0_IN_ACK_I))[*5]
    |-> BRIDGE_STATUS_O[3:2] == 2'h0; endproperty
a_selfall: assert property (p_selfall) else $error("in done not cleared");
endmodule
bind ubs_status ubs_status_chk chk_i (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I),
    .SERIAL_SELECT_I(SERIAL_SELECT_I), .WAKE_I(WAKE_I), .USB_RESET_I(USB_RESET_I),
    .USB_ACTIVE_I(USB_ACTIVE_I), .USB_RESUME_I(USB_RESUME_I), .EP12_IN_ACK_I(EP12_IN_ACK_I),
    .EP0_IN_ACK_I(EP0_IN_ACK_I), .OUT_ACK_I(OUT_ACK_I), .BRIDGE_STATUS_O(BRIDGE_STATUS_O),
    .STATUS_READ_O(STATUS_READ_O), .EP0_EN_SET_O(EP0_EN_SET_O), .STOP_OSC_O(STOP_OSC_O),
    .STOP_MCU_CLOCK_O(STOP_MCU_CLOCK_O));

//--- testbench/ubs_mcu_model.sv
`timescale 1ns/1ps
module ubs_mcu_model (
    input wire dout_i,
    output logic sel_o,
    output logic din_o,
    output logic sck_o
);
// ----------------
// serial master
// ----------------
// clock idles high, still between frames
initial
begin
    sel_o = 1'b1;
    din_o = 1'b0;
    sck_o = 1'b1;
end
task read_bits(input integer n, output logic [15:0] d);
    integer i;
    begin
        d = 16'h0000;
        sel_o = 1'b0;
        #200 din_o = 1'b1;
        #260 din_o = 1'b0;
        #200;
        for (i = 0; i < n; i++)
        begin
            sck_o = 1'b0;
            #62.5 sck_o = 1'b1;
            d[i] = dout_i;
            #62.5;
        end
        #200 sel_o = 1'b1;
        #200;
    end
endtask
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
logic clk = 1'b0;
logic rst_b = 1'b0;
logic wake = 1'b0;
logic usb_rst = 1'b0;
logic usb_busy = 1'b0;
logic usb_resume = 1'b0;
logic stop_osc = 1'b0;
logic stop_mcu = 1'b0;
logic [2:0] ack = 3'h0;
logic [7:0] nxt = 8'h00;
logic [15:0] d;
wire sel, din, sck, dout, so, mcu_gated;
wire req, rd, ep0_en;
wire [7:0] st;
integer fails = 0;
integer total_checks = 0;
integer req_cnt = 0;
integer rd_cnt = 0;
integer en_cnt = 0;
always #5 clk = ~clk;
ubs_status uut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .SERIAL_DATA_IN_I(din), .SERIAL_SELECT_I(sel),
    .SERIAL_CLK_I(sck), .WAKE_I(wake), .USB_RESET_I(usb_rst), .USB_ACTIVE_I(usb_busy),
    .USB_RESUME_I(usb_resume), .EP12_IN_ACK_I(ack[2]), .EP0_IN_ACK_I(ack[1]), .OUT_ACK_I(ack[0]),
    .STOP_OSC_I(stop_osc), .STOP_MCU_CLOCK_I(stop_mcu), .NEXT_BYTE_I(nxt), .NEXT_BYTE_REQ_O(req),
    .SERIAL_DATA_OUT_O(dout), .BRIDGE_STATUS_O(st), .STATUS_READ_O(rd), .EP0_EN_SET_O(ep0_en),
    .STOP_OSC_O(so), .STOP_MCU_CLOCK_O(mcu_gated));
ubs_mcu_model mcu (.dout_i(dout), .sel_o(sel), .din_o(din), .sck_o(sck));
// ----------------
// pulse counters
// ----------------
always @(posedge clk)
begin
    if (req === 1'b1)
        req_cnt <= req_cnt + 1;
    if (rd === 1'b1)
        rd_cnt <= rd_cnt + 1;
    if (ep0_en === 1'b1)
        en_cnt <= en_cnt + 1;
end
// ----------------
// helpers
// ----------------
task step(input integer n);
    repeat (n) @(posedge clk);
    #1;
endtask
task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
        fails++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task pulse_ack(input logic [2:0] m);
    ack = m;
    step(1);
    ack = 3'h0;
    step(4);
endtask
task print_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
// ----------------
// scenarios
// ----------------
task t_reset;
    chk(st, 8'h81);
    $display("reset test done");
endtask
task t_usb_reset;
    usb_rst = 1'b1;
    step(8);
    chk(st, 8'h41);
    usb_rst = 1'b0;
    step(8);
    chk(st, 8'h41);
    $display("bus reset test done");
endtask
task t_read;
    usb_busy = 1'b1;
    step(6);
    usb_busy = 1'b0;
    pulse_ack(3'h1);
    chk({7'h00, dout}, 8'h00);
    nxt = 8'h5a;
    mcu.read_bits(16, d);
    step(6);
    chk(d[7:0], 8'h63);
    chk(d[15:8], 8'h5a);
    chk(st, 8'h01);
    chk({7'h00, dout}, 8'h01);
    chk(rd_cnt[7:0], 8'h01);
    chk(req_cnt[7:0], 8'h02);
    chk(en_cnt[7:0], 8'h01);
    $display("read test done");
endtask
task t_in_done;
    pulse_ack(3'h6);
    chk(st, 8'h0d);
    chk({7'h00, dout}, 8'h00);
    mcu.read_bits(0, d);
    step(6);
    chk(st, 8'h01);
    chk({7'h00, dout}, 8'h00);
    chk(rd_cnt[7:0], 8'h01);
    $display("in done test done");
endtask
task t_stop;
    stop_osc = 1'b1;
    stop_mcu = 1'b1;
    step(2);
    chk({6'h00, so, mcu_gated}, 8'h03);
    usb_resume = 1'b1;
    step(8);
    chk(st, 8'h11);
    chk({6'h00, so, mcu_gated}, 8'h00);
    usb_resume = 1'b0;
    step(8);
    chk(st, 8'h01);
    wake = 1'b1;
    step(6);
    chk(st, 8'h00);
    wake = 1'b0;
    $display("stop test done");
endtask
initial
begin
    step(4);
    rst_b = 1'b1;
    step(4);
    t_reset;
    t_usb_reset;
    t_read;
    t_in_done;
    t_stop;
    print_verdict;
end
// generous against a run of a few microseconds
initial
begin
    #50000;
    fails++;
    print_verdict;
end
endmodule
